// >>> osc_clk_regs.svh
`ifndef OSC_CLK_REGS_SVH
`define OSC_CLK_REGS_SVH

// Monitor-disable position within the system configuration word.
`define MON_DIS_BIT      4
// Free-running cycles without a crystal edge before failure.
`define MON_OVF_CYC      16
`define MON_CNT_W        4

// Strap codes.
`define STRAP_X4         3'h7
`define STRAP_X3         3'h6
`define STRAP_X8         3'h5
`define STRAP_X5         3'h4
`define STRAP_DIRECT     3'h3
`define STRAP_X10        3'h2
`define STRAP_PRESC      3'h1
`define STRAP_X16        3'h0

// VCO multipliers and dividers.
`define VCO_MUL_64       7'h40
`define VCO_MUL_48       7'h30
`define VCO_MUL_40       7'h28
`define DIV_4            3'h4
`define DIV_2            3'h2

// Reference cycles per free-running tick.
`define FREE_DIV_DEF     4
// Bidirectional reset low time in half CPU periods.
`define BIDIR_RST_TCL    1024

`endif

// >>> osc_clk_pkg.sv
package osc_clk_pkg;

    typedef logic [2:0] strap_t;

    typedef enum logic [1:0] {
        SRC_DIRECT = 2'h0,
        SRC_BACKUP = 2'h1,
        SRC_PRESC  = 2'h3,
        SRC_PLL    = 2'h2
    } src_t;

    typedef struct packed {
        logic [6:0] vco_mul;
        logic [2:0] in_div;
        logic [2:0] post_div;
        logic       out_div2;
        logic       bypass;
    } pll_cfg_t;

endpackage

// >>> osc_monitor_clock_select.sv
`timescale 1ns/1ps
`include "osc_clk_regs.svh"

module osc_monitor_clock_select
    import osc_clk_pkg::*;
#(
    parameter int FREE_DIV = `FREE_DIV_DEF,
    parameter int RST_TCL  = `BIDIR_RST_TCL
) (
    // Clock and reset
    input  wire logic     I_REF_CLK,
    input  wire logic     I_RST_B,
    // Straps and configuration
    input  wire logic [2:0] I_STRAP,
    input  wire logic     I_MON_DIS,
    // Crystal and PLL status
    input  wire logic     I_XTAL,
    input  wire logic     I_PLL_UNLOCK,
    // Flag clear and bidirectional reset request
    input  wire logic     I_IRQ_CLR,
    input  wire logic     I_BIDIR_RST_REQ,
    // Reset pin, open drain
    input  wire logic     I_RESET_INPUT_PIN_PIN,
    output logic          O_RESET_INPUT_PIN_OUT,
    output logic          O_RESET_INPUT_PIN_OE,
    // Clock selection
    output src_t          O_CLK_SRC,
    output pll_cfg_t      O_PLL_CFG,
    output logic          O_PLL_ON,
    output logic          O_REF_CONN,
    output logic          O_RESYNC,
    // Monitor status and flags
    output logic          O_MON_ACT,
    output logic [3:0]    O_MON_CNT,
    output logic          O_MON_IRQ,
    output logic          O_UNLOCK_IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // Strap decoding.
    function automatic pll_cfg_t cfg_of(input strap_t s);
        pll_cfg_t c;
        c = '0;
        unique case (s)
            `STRAP_X4:     c = '{`VCO_MUL_64, `DIV_4, `DIV_4, 1'b0, 1'b0};
            `STRAP_X3:     c = '{`VCO_MUL_48, `DIV_4, `DIV_4, 1'b0, 1'b0};
            `STRAP_X8:     c = '{`VCO_MUL_64, `DIV_4, `DIV_2, 1'b0, 1'b0};
            `STRAP_X5:     c = '{`VCO_MUL_40, `DIV_4, `DIV_2, 1'b0, 1'b0};
            `STRAP_X10:    c = '{`VCO_MUL_40, `DIV_2, `DIV_2, 1'b0, 1'b0};
            `STRAP_X16:    c = '{`VCO_MUL_64, `DIV_2, `DIV_2, 1'b0, 1'b0};
            `STRAP_DIRECT: c = '{7'h00, 3'h0, 3'h0, 1'b0, 1'b1};
            `STRAP_PRESC:  c = '{7'h00, 3'h0, 3'h0, 1'b1, 1'b1};
        endcase
        return c;
    endfunction

    // Multiplication factor F, as count of edges minus one.
    function automatic logic [3:0] fm1_of(input strap_t s);
        logic [3:0] f;
        f = 4'h0;
        unique case (s)
            `STRAP_X4:  f = 4'h3;
            `STRAP_X3:  f = 4'h2;
            `STRAP_X8:  f = 4'h7;
            `STRAP_X5:  f = 4'h4;
            `STRAP_X10: f = 4'h9;
            `STRAP_X16: f = 4'hF;
            `STRAP_DIRECT, `STRAP_PRESC: f = 4'h0;
        endcase
        return f;
    endfunction

    function automatic src_t src_of(input strap_t s);
        src_t r;
        unique case (s)
            `STRAP_DIRECT: r = SRC_DIRECT;
            `STRAP_PRESC:  r = SRC_PRESC;
            default:       r = SRC_PLL;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.
    localparam logic [3:0] CNT_LAST = 4'(`MON_OVF_CYC - 1);
    localparam int         DIV_W    = $clog2(FREE_DIV + 1);
    localparam int         RST_W    = $clog2(RST_TCL + 1);

    strap_t           strap_ff;
    logic             xs1_ff;
    logic             xs2_ff;
    logic             xs3_ff;
    logic             xedge;
    logic [DIV_W-1:0] div_ff;
    logic             tick_ff;
    logic             fail_ff;
    logic             counting;
    logic [3:0]       res_ff;
    logic [RST_W-1:0] rst_cnt_ff;
    logic             pll_mode;

    assign xedge    = xs2_ff ^ xs3_ff;
    assign pll_mode = (O_CLK_SRC == SRC_PLL);
    assign counting = O_MON_ACT && !fail_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture and clock configuration.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            strap_ff  <= I_STRAP;
            O_PLL_CFG <= cfg_of(I_STRAP);
        end
        // Later strap changes are ignored until the next reset.
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            O_CLK_SRC <= src_of(I_STRAP);
        end else if (tick_ff && counting && xedge == 1'b0 && O_MON_CNT == CNT_LAST) begin
            O_CLK_SRC <= SRC_BACKUP;
        end
    end

    // Monitoring applies only to the bypass codes.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            O_MON_ACT <= 1'b0;
        end else begin
            O_MON_ACT <= O_PLL_CFG.bypass && !I_MON_DIS && !fail_ff;
        end
    end

    // The PLL runs for multiplication, for monitoring, or as backup.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            O_PLL_ON <= 1'b0;
        end else begin
            O_PLL_ON <= !O_PLL_CFG.bypass || !I_MON_DIS || fail_ff;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            O_REF_CONN <= (src_of(I_STRAP) == SRC_PLL);
        end else if (pll_mode && I_PLL_UNLOCK) begin
            O_REF_CONN <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crystal edge synchroniser.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            xs1_ff <= 1'b0;
            xs2_ff <= 1'b0;
            xs3_ff <= 1'b0;
        end else begin
            xs1_ff <= I_XTAL;
            xs2_ff <= xs1_ff;
            xs3_ff <= xs2_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Free-running clock tick.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B || !O_PLL_ON) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == DIV_W'(FREE_DIV - 1)) begin
            div_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Monitor counter.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B || !counting) begin
            O_MON_CNT <= 4'h0;
        end else if (xedge) begin
            O_MON_CNT <= 4'h0;
        end else if (tick_ff && O_MON_CNT != CNT_LAST) begin
            O_MON_CNT <= O_MON_CNT + 4'h1;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            fail_ff <= 1'b0;
        end else if (tick_ff && counting && !xedge && O_MON_CNT == CNT_LAST) begin
            fail_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt flags; a new event wins over a clear.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            O_MON_IRQ <= 1'b0;
        end else if (tick_ff && counting && !xedge && O_MON_CNT == CNT_LAST) begin
            O_MON_IRQ <= 1'b1;
        end else if (I_IRQ_CLR) begin
            O_MON_IRQ <= 1'b0;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            O_UNLOCK_IRQ <= 1'b0;
        end else if (pll_mode && O_REF_CONN && I_PLL_UNLOCK) begin
            O_UNLOCK_IRQ <= 1'b1;
        end else if (I_IRQ_CLR) begin
            O_UNLOCK_IRQ <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Resynchronisation pulse on every F-th crystal transition.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B || !pll_mode || !O_REF_CONN) begin
            res_ff   <= 4'h0;
            O_RESYNC <= 1'b0;
        end else if (xedge && res_ff == fm1_of(strap_ff)) begin
            res_ff   <= 4'h0;
            O_RESYNC <= 1'b1;
        end else begin
            res_ff   <= xedge ? res_ff + 4'h1 : res_ff;
            O_RESYNC <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bidirectional reset pin driver; the count survives the reset it causes.
    always_ff @(posedge I_REF_CLK) begin
        if (O_RESET_INPUT_PIN_OE) begin
            rst_cnt_ff <= rst_cnt_ff + 1'b1;
            O_RESET_INPUT_PIN_OE <= rst_cnt_ff != RST_W'(RST_TCL - 1);
        end else if (!I_RST_B) begin
            rst_cnt_ff <= '0;
            O_RESET_INPUT_PIN_OE <= 1'b0;
        end else if (I_BIDIR_RST_REQ && I_RESET_INPUT_PIN_PIN) begin
            rst_cnt_ff <= '0;
            O_RESET_INPUT_PIN_OE <= 1'b1;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        O_RESET_INPUT_PIN_OUT <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_mon_on;
        @(posedge I_REF_CLK) disable iff (!I_RST_B)
        O_PLL_CFG.bypass && !I_MON_DIS && !fail_ff |=> O_MON_ACT;
    endproperty
    a_mon_on: assert property (p_mon_on) else $error("monitor not enabled");
    property p_count;
        @(posedge I_REF_CLK) disable iff (!I_RST_B)
        counting && tick_ff && !xedge && O_MON_CNT != CNT_LAST
        |=> O_MON_CNT == $past(O_MON_CNT) + 4'h1;
    endproperty
    a_count: assert property (p_count) else $error("counter did not step");
    property p_clear;
        @(posedge I_REF_CLK) disable iff (!I_RST_B)
        xedge |=> O_MON_CNT == 4'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("edge did not clear");
    property p_ovf;
        @(posedge I_REF_CLK) disable iff (!I_RST_B)
        counting && tick_ff && !xedge && O_MON_CNT == CNT_LAST |=> fail_ff && O_MON_IRQ;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow missed");
    property p_switch;
        @(posedge I_REF_CLK) disable iff (!I_RST_B)
        $rose(fail_ff) |-> O_CLK_SRC == SRC_BACKUP && O_PLL_ON ##1 !O_MON_ACT;
    endproperty
    a_switch: assert property (p_switch) else $error("no backup switch");
    property p_stay;
        @(posedge I_REF_CLK) disable iff (!I_RST_B)
        O_CLK_SRC == SRC_BACKUP |=> O_CLK_SRC == SRC_BACKUP;
    endproperty
    a_stay: assert property (p_stay) else $error("left backup clock");
    property p_off;
        @(posedge I_REF_CLK) disable iff (!I_RST_B)
        O_PLL_CFG.bypass && I_MON_DIS && !fail_ff |=> !O_PLL_ON;
    endproperty
    a_off: assert property (p_off) else $error("PLL left on");
    property p_mul;
        @(posedge I_REF_CLK) disable iff (!I_RST_B)
        strap_ff == `STRAP_X3 |-> O_PLL_CFG.vco_mul == `VCO_MUL_48
                                  && O_PLL_CFG.post_div == `DIV_4;
    endproperty
    a_mul: assert property (p_mul) else $error("bad multiplier");
    property p_unlock;
        @(posedge I_REF_CLK) disable iff (!I_RST_B)
        pll_mode && O_REF_CONN && I_PLL_UNLOCK |=> !O_REF_CONN && O_UNLOCK_IRQ;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock not handled");
    property p_rst_len;
        @(posedge I_REF_CLK)
        $rose(O_RESET_INPUT_PIN_OE) |-> O_RESET_INPUT_PIN_OE[*8];
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pulse short");
    property p_strap;
        @(posedge I_REF_CLK)
        I_RST_B && $past(I_RST_B) |-> $stable(strap_ff);
    endproperty
    a_strap: assert property (p_strap) else $error("strap changed");

endmodule

// >>> xtal_source_model.sv
`timescale 1ns/1ps

// Crystal source that toggles every i_half reference cycles while running.
// A stopped crystal holds its last level, which is what a failed oscillator shows.
module xtal_source_model (
    // Clock
    input  wire logic       i_clk,
    // Control
    input  wire logic       i_run,
    input  wire logic [3:0] i_half,
    // Crystal output
    output logic            o_xtal
);
    logic [3:0] cnt_ff = 4'h0;

    initial o_xtal = 1'b0;

    // The bench picks the rate so the derived clocks stay in range.
    always @(posedge i_clk) begin
        if (i_run && cnt_ff + 4'h1 >= i_half) begin
            cnt_ff <= 4'h0;
            o_xtal <= ~o_xtal;
        end else if (i_run) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule

// >>> osc_monitor_pll_clock_select_tb.sv
`timescale 1ns/1ps
`include "osc_clk_regs.svh"

module osc_monitor_pll_clock_select_tb import osc_clk_pkg::*; ();
    localparam int FDIV = 4;
    localparam int HALF_CPU_PERIOD  = 16;

    logic       ref_clk, rst_b, mon_dis, pll_unlock, irq_clr, bidir_req, run;
    strap_t     strap;
    logic [3:0] half;
    wire        xtal;
    logic       reset_input_pin_out, reset_input_pin_oe, pll_on, ref_conn, resync, mon_act, mon_irq, unlock_irq;
    src_t       clk_src;
    pll_cfg_t   cfg;
    logic [3:0] mon_cnt;
    int         num_errors, checks;

    // The reset pin has a pull-up, so it reads high unless driven.
    wire reset_input_pin_pin = reset_input_pin_oe ? reset_input_pin_out : 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    xtal_source_model u_xtal (.i_clk(ref_clk), .i_run(run), .i_half(half), .o_xtal(xtal));

    osc_monitor_clock_select #(.FREE_DIV(FDIV), .RST_TCL(HALF_CPU_PERIOD)) u_dut (
        .I_REF_CLK(ref_clk), .I_RST_B(rst_b), .I_STRAP(strap), .I_MON_DIS(mon_dis),
        .I_XTAL(xtal), .I_PLL_UNLOCK(pll_unlock), .I_IRQ_CLR(irq_clr),
        .I_BIDIR_RST_REQ(bidir_req), .I_RESET_INPUT_PIN_PIN(reset_input_pin_pin), .O_RESET_INPUT_PIN_OUT(reset_input_pin_out),
        .O_RESET_INPUT_PIN_OE(reset_input_pin_oe), .O_CLK_SRC(clk_src), .O_PLL_CFG(cfg), .O_PLL_ON(pll_on),
        .O_REF_CONN(ref_conn), .O_RESYNC(resync), .O_MON_ACT(mon_act), .O_MON_CNT(mon_cnt),
        .O_MON_IRQ(mon_irq), .O_UNLOCK_IRQ(unlock_irq));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic chk_cfg(input pll_cfg_t got, input pll_cfg_t exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic do_reset(input strap_t s, input logic dis);
        @(posedge ref_clk);
        rst_b   <= 1'b0;
        strap   <= s;
        mon_dis <= dis;
        cyc(3);
        rst_b <= 1'b1;
        cyc(2);
        #1;
    endtask

    // Waits for a flag to reach a level, giving up after a bound.
    // Select 0 watches the failure flag, select 1 the reset pin enable.
    task automatic wait_lvl(input logic sel, input logic lvl, output int n);
        n = 0;
        while ((sel ? reset_input_pin_oe : mon_irq) !== lvl && n < 2000) begin
            cyc(1);
            #1;
            n++;
        end
        if (n >= 2000) begin
            num_errors++;
            end_of_test();
        end
    endtask

    function automatic pll_cfg_t exp_cfg(input strap_t s);
        pll_cfg_t c;
        c = '0;
        case (s)
            `STRAP_X4, `STRAP_X8, `STRAP_X16: c.vco_mul = `VCO_MUL_64;
            `STRAP_X3:                        c.vco_mul = `VCO_MUL_48;
            `STRAP_X5, `STRAP_X10:            c.vco_mul = `VCO_MUL_40;
            default:                          c.bypass  = 1'b1;
        endcase
        if (!c.bypass) begin
            c.in_div   = s[2] ? `DIV_4 : `DIV_2;
            c.post_div = (s[2:1] == 2'b11) ? `DIV_4 : `DIV_2;
        end
        c.out_div2 = (s == `STRAP_PRESC);
        return c;
    endfunction

    function automatic src_t exp_src(input strap_t s);
        return (s == `STRAP_DIRECT) ? SRC_DIRECT : (s == `STRAP_PRESC) ? SRC_PRESC : SRC_PLL;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        rst_b = 1'b0; strap = 3'h7; mon_dis = 1'b0; pll_unlock = 1'b0;
        irq_clr = 1'b0; bidir_req = 1'b0; run = 1'b1; half = 4'h2;
        num_errors = 0; checks = 0;
        for (int i = 0; i < 8; i++) begin
            do_reset(strap_t'(i), 1'b0);
            chk_cfg(cfg, exp_cfg(strap_t'(i)));
            chk_val(16'(clk_src), 16'(exp_src(strap_t'(i))));
            chk_val(16'(pll_on), 16'h0001);
            chk_val(16'(mon_act), 16'((i == 1) || (i == 3)));
        end
        // Strap pins move after release; the latched code must not.
        cyc(1);
        strap <= 3'h0;
        cyc(3);
        #1;
        chk_cfg(cfg, exp_cfg(3'h7));
        // Eighty crystal transitions at factor four give twenty resyncs.
        cyc(1);
        half <= 4'h3;
        n = 0;
        repeat (240) begin
            cyc(1);
            #1;
            n += int'(resync === 1'b1);
        end
        chk_val(16'(n >= 19 && n <= 21), 16'h0001);
        cyc(1);
        run <= 1'b0;
        cyc(150);
        #1;
        chk_val(16'(mon_irq), 16'h0000);
        chk_val(16'(clk_src), 16'(SRC_PLL));
        cyc(1);
        pll_unlock <= 1'b1;
        cyc(1);
        pll_unlock <= 1'b0;
        cyc(1);
        #1;
        chk_val(16'({ref_conn, unlock_irq}), 16'h0001);
        cyc(50);
        #1;
        chk_val(16'(ref_conn), 16'h0000);
        cyc(1);
        irq_clr <= 1'b1;
        cyc(1);
        irq_clr <= 1'b0;
        cyc(1);
        #1;
        chk_val(16'(unlock_irq), 16'h0000);
        do_reset(3'h7, 1'b0);
        chk_val(16'(ref_conn), 16'h0001);
        // Monitor in direct mode: a live crystal keeps it quiet, a dead one trips it.
        cyc(1);
        half <= 4'h2;
        run  <= 1'b1;
        do_reset(3'h3, 1'b0);
        cyc(100);
        #1;
        chk_val(16'({clk_src, mon_irq}), 16'({SRC_DIRECT, 1'b0}));
        chk_val(16'(mon_cnt <= 4'h1), 16'h0001);
        cyc(1);
        run <= 1'b0;
        #1;
        wait_lvl(1'b0, 1'b1, n);
        chk_val(16'(n >= 16 * FDIV - 4 && n <= 16 * FDIV + 8), 16'h0001);
        chk_val(16'(clk_src), 16'(SRC_BACKUP));
        cyc(1);
        run <= 1'b1;
        cyc(100);
        #1;
        chk_val(16'(clk_src), 16'(SRC_BACKUP));
        do_reset(3'h3, 1'b0);
        chk_val(16'({clk_src, mon_irq}), 16'({SRC_DIRECT, 1'b0}));
        // Monitor disabled: a dead crystal is ignored and the PLL stays off.
        do_reset(3'h1, 1'b1);
        cyc(1);
        run <= 1'b0;
        cyc(150);
        #1;
        chk_val(16'({clk_src, mon_irq, pll_on, mon_act}), 16'({SRC_PRESC, 3'h0}));
        cyc(1);
        bidir_req <= 1'b1;
        cyc(1);
        bidir_req <= 1'b0;
        #1;
        chk_val(16'({reset_input_pin_oe, reset_input_pin_out}), 16'h0002);
        wait_lvl(1'b1, 1'b0, n);
        chk_val(16'(n), 16'(HALF_CPU_PERIOD));
        end_of_test();
    end
endmodule
